// [src/ebr_cfg.svh]
// Constants for the embedded block RAM: register offsets, reset values,
// mode codes and data-path sizes.
// Assumes inclusion by bare name from every file that needs the figures.
`ifndef EBR_CFG_SVH
`define EBR_CFG_SVH

// ==========================================================================
// Register map (byte addresses, one aligned word each)
`define EBR_OFS_CTRL   8'h00
`define EBR_OFS_STAT   8'h04
`define EBR_CTRL_RST   16'h0000

// ==========================================================================
// Memory use codes
`define EBR_MEM_SP     3'h0
`define EBR_MEM_SDP    3'h1
`define EBR_MEM_TDP    3'h2
`define EBR_MEM_ROM    3'h3
`define EBR_MEM_FIFO   3'h4
`define EBR_MEM_SHR    3'h5

// ==========================================================================
// Clocking scheme codes
`define EBR_CLK_SC     2'h0
`define EBR_CLK_IND    2'h1
`define EBR_CLK_IO     2'h2
`define EBR_CLK_RW     2'h3

// ==========================================================================
// Width codes 0..8 give x1 x2 x4 x8 x9 x16 x18 x32 x36
`define EBR_WC_32      4'h7
`define EBR_WC_MAX     4'h8

// ==========================================================================
// Data path
`define EBR_DONT_CARE  36'hf_ffff_ffff
`define EBR_STAT_ERR   0
`define EBR_STAT_COLL  16

`endif

// [src/ebr_pkg.sv]
// Types shared by the block RAM top and its storage array.
// Assumes ebr_cfg.svh for all numeric constants.
`default_nettype none

package ebr_pkg;

  // ========================================================================
  // Fabric side of one memory port
  typedef struct packed {
    logic [12:0] addr;
    logic [35:0] wdata;
    logic        we;
    logic        re;
    logic        in_ce;
    logic        out_ce;
    logic        clr;
  } ebr_port_in_t;

  // ========================================================================
  // Control register layout, bit 15 down to bit 0
  typedef struct packed {
    logic       mp_old;
    logic       sp_new;
    logic [3:0] wcode_b;
    logic [3:0] wcode_a;
    logic [1:0] clk;
    logic [2:0] mem;
    logic       en;
  } ebr_ctrl_t;

  typedef enum logic [1:0] {EBR_OVR_NONE, EBR_OVR_NEW, EBR_OVR_DC} ebr_ovr_t;

  // ========================================================================
  // One port's registers
  typedef struct packed {
    logic        fire;
    logic        we;
    logic        re;
    logic [12:0] waddr;
    logic [12:0] raddr;
    logic [35:0] wdata;
    logic        rv;
    logic [5:0]  rsh;
    logic [5:0]  rwid;
    ebr_ovr_t    ovr;
    logic [35:0] nd;
    logic [35:0] q;
    logic        seen;
  } ebr_port_st_t;

  typedef struct packed {
    ebr_ctrl_t    ctrl;
    logic [15:0]  coll;
    logic         ahb_wr;
    logic [7:0]   ahb_addr;
    logic [31:0]  hrdata;
    ebr_port_st_t a;
    ebr_port_st_t b;
  } ebr_state_t;

  // ========================================================================
  // Row access toward the storage array
  typedef struct packed {
    logic        en;
    logic        we;
    logic [7:0]  row;
    logic [35:0] wmask;
    logic [35:0] wdata;
  } ebr_ram_req_t;

endpackage

`default_nettype wire

// [src/ebr_ram_array.sv]
// Storage array of the block RAM: 256 rows of 36 bits, two row ports.
// Assumes the top module supplies row, bit mask and placed write data.
`timescale 1ns/1ps
`default_nettype none

module ebr_ram_array (
  // Clock
  input  wire logic                  hclk,
  // Port A
  input  wire ebr_pkg::ebr_ram_req_t req_a,
  output logic [35:0]                rd_a,
  // Port B
  input  wire ebr_pkg::ebr_ram_req_t req_b,
  output logic [35:0]                rd_b
);

  logic [35:0] mem [0:255];
  logic [35:0] mrg_a;
  logic [35:0] base_b;
  logic        same_row;

  // ========================================================================
  // Merge so that two writes into one row keep both lanes; B wins on overlap
  assign same_row = req_a.en && req_a.we && req_b.en && req_b.we && (req_a.row == req_b.row);

  always_comb begin
    mrg_a  = (mem[req_a.row] & ~req_a.wmask) | (req_a.wdata & req_a.wmask);
    base_b = same_row ? mrg_a : mem[req_b.row];
  end

  // ========================================================================
  // Reads return the row as it stood before this edge's writes
  always_ff @(posedge hclk) begin
    if (req_a.en) begin
      rd_a <= mem[req_a.row];
    end
    if (req_b.en) begin
      rd_b <= mem[req_b.row];
    end
    if (req_a.en && req_a.we && !same_row) begin
      mem[req_a.row] <= mrg_a;
    end
    if (req_b.en && req_b.we) begin
      mem[req_b.row] <= (base_b & ~req_b.wmask) | (req_b.wdata & req_b.wmask);
    end
  end

endmodule

`default_nettype wire

// [src/ebr_top.sv]
// Embedded block RAM with two fabric ports and an AHB-Lite control slave.
// Assumes fabric ports and the bus run on hclk; clocking schemes are
// realised as per-port clock enables on that single clock.
`include "ebr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module ebr_top (
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // Fabric ports
  input  wire ebr_pkg::ebr_port_in_t port_a,
  input  wire ebr_pkg::ebr_port_in_t port_b,
  output logic [35:0]                q_a,
  output logic [35:0]                q_b
);

  // ========================================================================
  // Decode helpers
  function automatic logic [5:0] wid(input logic [3:0] c);
    case (c)
      4'h0:    wid = 6'h01;
      4'h1:    wid = 6'h02;
      4'h2:    wid = 6'h04;
      4'h3:    wid = 6'h08;
      4'h4:    wid = 6'h09;
      4'h5:    wid = 6'h10;
      4'h6:    wid = 6'h12;
      4'h7:    wid = 6'h20;
      4'h8:    wid = 6'h24;
      default: wid = 6'h01;
    endcase
  endfunction

  // Log2 of words per 36-bit row
  function automatic logic [2:0] l2(input logic [3:0] c);
    case (c)
      4'h0:    l2 = 3'h5;
      4'h1:    l2 = 3'h4;
      4'h2:    l2 = 3'h3;
      4'h3:    l2 = 3'h2;
      4'h4:    l2 = 3'h2;
      4'h5:    l2 = 3'h1;
      4'h6:    l2 = 3'h1;
      default: l2 = 3'h0;
    endcase
  endfunction

  function automatic logic [7:0] row_of(input logic [12:0] a, input logic [3:0] c);
    row_of = 8'(a >> l2(c));
  endfunction

  function automatic logic [5:0] sh_of(input logic [12:0] a, input logic [3:0] c);
    logic [4:0] ln;
    ln    = a[4:0] & 5'((6'h01 << l2(c)) - 6'h01);
    sh_of = 6'({1'b0, ln} * wid(c));
  endfunction

  function automatic logic [35:0] msk(input logic [5:0] sh, input logic [5:0] w);
    msk = 36'(((37'h1 << w) - 37'h1) << sh);
  endfunction

  function automatic logic clk_ok(input logic [2:0] m, input logic [1:0] k);
    case (k)
      `EBR_CLK_SC:  clk_ok = 1'b1;
      `EBR_CLK_IND: clk_ok = (m == `EBR_MEM_TDP) || (m == `EBR_MEM_ROM);
      `EBR_CLK_IO:  clk_ok = (m == `EBR_MEM_TDP) || (m == `EBR_MEM_SDP) ||
                             (m == `EBR_MEM_SP) || (m == `EBR_MEM_ROM);
      default:      clk_ok = (m == `EBR_MEM_SDP) || (m == `EBR_MEM_FIFO) ||
                             (m == `EBR_MEM_SHR);
    endcase
  endfunction

  function automatic logic cfg_bad(input ebr_pkg::ebr_ctrl_t c);
    cfg_bad = (c.wcode_a > `EBR_WC_MAX) || (c.wcode_b > `EBR_WC_MAX) ||
              (c.mem > `EBR_MEM_SHR) || !clk_ok(c.mem, c.clk) ||
              ((c.mem == `EBR_MEM_TDP) &&
               ((c.wcode_a >= `EBR_WC_32) || (c.wcode_b >= `EBR_WC_32)));
  endfunction

  // Port roles {write A, read A, write B, read B}; FIFO and shift register
  // only get the raw write/read ports, pointers come from the fabric
  function automatic logic [3:0] roles(input logic [2:0] m);
    case (m)
      `EBR_MEM_SP:  roles = 4'b1100;
      `EBR_MEM_TDP: roles = 4'b1111;
      `EBR_MEM_ROM: roles = 4'b0101;
      `EBR_MEM_SDP,
      `EBR_MEM_FIFO,
      `EBR_MEM_SHR: roles = 4'b1001;
      default:      roles = 4'b0000;
    endcase
  endfunction

  // Enables {in A, out A, in B, out B} per clocking scheme
  function automatic logic [3:0] ces(input logic [1:0] k, input ebr_pkg::ebr_port_in_t a,
                                     input ebr_pkg::ebr_port_in_t b);
    case (k)
      `EBR_CLK_SC:  ces = {4{a.in_ce}};
      `EBR_CLK_IND: ces = {a.in_ce, a.in_ce, b.in_ce, b.in_ce};
      `EBR_CLK_IO:  ces = {a.in_ce, a.out_ce, a.in_ce, a.out_ce};
      default:      ces = {a.in_ce, a.in_ce, b.in_ce, b.in_ce};
    endcase
  endfunction

  function automatic ebr_pkg::ebr_ovr_t ovr_of(input logic hit, input logic dc, input logic same);
    if (hit) begin
      ovr_of = dc ? ebr_pkg::EBR_OVR_DC : ebr_pkg::EBR_OVR_NONE;
    end else begin
      ovr_of = same ? ebr_pkg::EBR_OVR_NEW : ebr_pkg::EBR_OVR_NONE;
    end
  endfunction

  function automatic logic [35:0] res_of(input ebr_pkg::ebr_port_st_t s, input logic [35:0] rd);
    case (s.ovr)
      ebr_pkg::EBR_OVR_NEW: res_of = s.nd;
      ebr_pkg::EBR_OVR_DC:  res_of = `EBR_DONT_CARE & msk(6'h00, s.rwid);
      default:              res_of = (rd >> s.rsh) & msk(6'h00, s.rwid);
    endcase
  endfunction

  // One port: input capture, access bookkeeping, output register, clear
  function automatic ebr_pkg::ebr_port_st_t step(
      input ebr_pkg::ebr_port_st_t s, input ebr_pkg::ebr_port_in_t p,
      input logic ci, input logic co, input logic rg, input logic [5:0] sh,
      input logic [5:0] w, input ebr_pkg::ebr_ovr_t ov, input logic [35:0] res);
    step      = s;
    step.fire = ci;
    if (ci) begin
      step.we    = p.we;
      step.re    = p.re;
      step.waddr = p.addr;
      step.raddr = p.addr;
      step.wdata = p.wdata;
    end
    if (co && s.rv) begin
      step.q    = res;
      step.rv   = 1'b0;
      step.seen = 1'b1;
    end
    if (rg) begin
      step.rv   = 1'b1;
      step.rsh  = sh;
      step.rwid = w;
      step.ovr  = ov;
      step.nd   = s.wdata & msk(6'h00, w);
    end
    if (p.clr) begin
      step.raddr = 13'h0000;
      step.q     = 36'h0;
      step.rv    = 1'b0;
      step.seen  = 1'b0;
    end
  endfunction

  // ========================================================================
  // State and decode
  ebr_pkg::ebr_state_t   st_r;
  ebr_pkg::ebr_state_t   st_nxt;
  ebr_pkg::ebr_ram_req_t req_a;
  ebr_pkg::ebr_ram_req_t req_b;
  ebr_pkg::ebr_ovr_t     ov_a;
  ebr_pkg::ebr_ovr_t     ov_b;
  logic [3:0]            ce;
  logic [3:0]            rl;
  logic                  bad;
  logic                  ok;
  logic                  wg_a;
  logic                  rg_a;
  logic                  wg_b;
  logic                  rg_b;
  logic [5:0]            w_a;
  logic [5:0]            w_b;
  logic [5:0]            rs_a;
  logic [5:0]            rs_b;
  logic [5:0]            ws_a;
  logic [5:0]            ws_b;
  logic [35:0]           rm_a;
  logic [35:0]           rm_b;
  logic [35:0]           wm_a;
  logic [35:0]           wm_b;
  logic                  hit_a;
  logic                  hit_b;
  logic                  dc_mix;
  logic [35:0]           rd_a;
  logic [35:0]           rd_b;
  logic [35:0]           res_a;
  logic [35:0]           res_b;
  logic                  bus_acc;

  assign bad  = cfg_bad(st_r.ctrl);
  assign ok   = st_r.ctrl.en && !bad;
  assign rl   = roles(st_r.ctrl.mem);
  assign ce   = ces(st_r.ctrl.clk, port_a, port_b);
  assign w_a  = wid(st_r.ctrl.wcode_a);
  assign w_b  = wid(st_r.ctrl.wcode_b);
  assign wg_a = st_r.a.fire && ok && st_r.a.we && rl[3];
  assign rg_a = st_r.a.fire && ok && st_r.a.re && rl[2];
  assign wg_b = st_r.b.fire && ok && st_r.b.we && rl[1];
  assign rg_b = st_r.b.fire && ok && st_r.b.re && rl[0];
  assign rs_a = sh_of(st_r.a.raddr, st_r.ctrl.wcode_a);
  assign ws_a = sh_of(st_r.a.waddr, st_r.ctrl.wcode_a);
  assign rs_b = sh_of(st_r.b.raddr, st_r.ctrl.wcode_b);
  assign ws_b = sh_of(st_r.b.waddr, st_r.ctrl.wcode_b);
  assign rm_a = msk(rs_a, w_a);
  assign wm_a = msk(ws_a, w_a);
  assign rm_b = msk(rs_b, w_b);
  assign wm_b = msk(ws_b, w_b);

  // ========================================================================
  // Collisions; read/write clocking never guarantees the word
  assign hit_a  = rg_a && wg_b && |(rm_a & wm_b) &&
                  (row_of(st_r.a.raddr, st_r.ctrl.wcode_a) == row_of(st_r.b.waddr, st_r.ctrl.wcode_b));
  assign hit_b  = rg_b && wg_a && |(rm_b & wm_a) &&
                  (row_of(st_r.b.raddr, st_r.ctrl.wcode_b) == row_of(st_r.a.waddr, st_r.ctrl.wcode_a));
  assign dc_mix = (st_r.ctrl.clk == `EBR_CLK_RW) || !st_r.ctrl.mp_old;
  assign ov_a   = ovr_of(hit_a, dc_mix, wg_a && (st_r.a.waddr == st_r.a.raddr) && st_r.ctrl.sp_new);
  assign ov_b   = ovr_of(hit_b, dc_mix, wg_b && (st_r.b.waddr == st_r.b.raddr) && st_r.ctrl.sp_new);

  // ========================================================================
  // Row requests; write row wins, read and write address match unless cleared
  always_comb begin
    req_a.en    = wg_a || rg_a;
    req_a.we    = wg_a;
    req_a.row   = row_of(wg_a ? st_r.a.waddr : st_r.a.raddr, st_r.ctrl.wcode_a);
    req_a.wmask = wm_a;
    req_a.wdata = st_r.a.wdata << ws_a;
    req_b.en    = wg_b || rg_b;
    req_b.we    = wg_b;
    req_b.row   = row_of(wg_b ? st_r.b.waddr : st_r.b.raddr, st_r.ctrl.wcode_b);
    req_b.wmask = wm_b;
    req_b.wdata = st_r.b.wdata << ws_b;
  end

  ebr_ram_array u_array (
    .hclk  (hclk),
    .req_a (req_a),
    .rd_a  (rd_a),
    .req_b (req_b),
    .rd_b  (rd_b)
  );

  assign res_a = res_of(st_r.a, rd_a);
  assign res_b = res_of(st_r.b, rd_b);

  // ========================================================================
  // Next state
  assign bus_acc = hsel && htrans[1] && hready;

  always_comb begin
    st_nxt          = st_r;
    st_nxt.ahb_wr   = bus_acc && hwrite;
    st_nxt.ahb_addr = haddr[7:0];
    if (bus_acc && !hwrite) begin
      case (haddr[7:0])
        `EBR_OFS_CTRL: st_nxt.hrdata = {16'h0000, st_r.ctrl};
        `EBR_OFS_STAT: st_nxt.hrdata = {st_r.coll, 15'h0000, bad};
        default:       st_nxt.hrdata = 32'h0000_0000;
      endcase
    end
    if (st_r.ahb_wr && (st_r.ahb_addr == `EBR_OFS_CTRL)) begin
      st_nxt.ctrl = hwdata[15:0];
    end
    // Counter write clears; a collision in the same cycle still counts
    if (st_r.ahb_wr && (st_r.ahb_addr == `EBR_OFS_STAT)) begin
      st_nxt.coll = 16'h0000;
    end
    if (hit_a || hit_b) begin
      st_nxt.coll = st_nxt.coll + 16'h0001;
    end
    st_nxt.a = step(st_r.a, port_a, ce[3], ce[2], rg_a, rs_a, w_a, ov_a, res_a);
    st_nxt.b = step(st_r.b, port_b, ce[1], ce[0], rg_b, rs_b, w_b, ov_b, res_b);
  end

  // Reset clears outputs as well, so q reads zero until a read lands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r      <= '0;
      st_r.ctrl <= `EBR_CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_r.hrdata;
  assign q_a       = st_r.a.q;
  assign q_b       = st_r.b.q;

  // ========================================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  out_zero_a: assert property (!st_r.a.seen |-> q_a == 36'h0)
    else $error("q_a not zero before first read");
  tdp_wide_a: assert property ((st_r.ctrl.mem == `EBR_MEM_TDP) && (st_r.ctrl.wcode_a >= `EBR_WC_32)
                               |-> !req_a.we && !req_b.we)
    else $error("wide true dual-port write went through");
  sdp_mixed_a: assert property ((st_r.ctrl.mem == `EBR_MEM_SDP) && (st_r.ctrl.clk == `EBR_CLK_SC) &&
                                (st_r.ctrl.wcode_a <= `EBR_WC_MAX) && (st_r.ctrl.wcode_b <= `EBR_WC_MAX) |-> !bad)
    else $error("mixed simple dual-port refused");
  fifo_clk_a: assert property ((st_r.ctrl.mem == `EBR_MEM_FIFO) && (st_r.ctrl.clk == `EBR_CLK_IND) |-> bad)
    else $error("fifo accepted independent clocking");
  fire_edge_a: assert property (rg_a && !port_a.clr |=> st_r.a.rv && st_r.a.rsh == $past(rs_a))
    else $error("read not registered at edge");
  sp_new_a: assert property (rg_a && wg_a && !hit_a && st_r.ctrl.sp_new &&
                             (st_r.a.waddr == st_r.a.raddr) && !port_a.clr
                             |=> res_a == ($past(st_r.a.wdata) & msk(6'h00, st_r.a.rwid)))
    else $error("same-port new data not returned");
  mix_dc_a: assert property (hit_b && dc_mix && !port_b.clr |=> res_b == (`EBR_DONT_CARE & msk(6'h00, st_r.b.rwid)))
    else $error("mixed-port collision not flagged");
  rw_dc_b: assert property (hit_b && (st_r.ctrl.clk == `EBR_CLK_RW) && !port_b.clr
                            |=> st_r.b.ovr == ebr_pkg::EBR_OVR_DC)
    else $error("read/write collision gave defined data");
  clr_keep_a: assert property (port_a.clr && !ce[3] |=> st_r.a.raddr == 13'h0000 && q_a == 36'h0
                               && $stable(st_r.a.waddr) && $stable(st_r.a.wdata))
    else $error("clear touched write side or missed read side");
  ind_hold_a: assert property ((st_r.ctrl.clk == `EBR_CLK_IND) && !port_a.in_ce && port_b.in_ce
                               && !port_a.clr |=> $stable(st_r.a.raddr) && !st_r.a.fire)
    else $error("port A moved on port B enable");
  io_out_a: assert property ((st_r.ctrl.clk == `EBR_CLK_IO) && !port_a.out_ce && !port_a.clr
                             |=> $stable(q_a))
    else $error("output changed without output enable");
  rw_rd_b: assert property ((st_r.ctrl.clk == `EBR_CLK_RW) && port_b.in_ce && !port_b.clr
                            |=> st_r.b.raddr == $past(port_b.addr))
    else $error("read side ignored its enable");
  sc_hold_a: assert property ((st_r.ctrl.clk == `EBR_CLK_SC) && !port_a.in_ce
                              |=> !st_r.a.fire && !st_r.b.fire)
    else $error("single clock enable ignored");

  same_rdw_c: cover property (rg_a && wg_a && st_r.ctrl.sp_new);
  mix_hit_c: cover property (hit_b ##2 st_r.b.seen);
  cfg_err_c: cover property (bad && port_a.in_ce);
  bus_wr_c: cover property (st_r.ahb_wr && st_r.ahb_addr == `EBR_OFS_CTRL);

endmodule

`default_nettype wire

// [dv/ebr_fabric_model.sv]
// Partner model: fabric logic driving both memory ports on hclk.
// Assumes the memory samples every port field on the rising edge of hclk.
`timescale 1ns/1ps
`default_nettype none

module ebr_fabric_model (
  // Clock
  input  wire logic                 hclk,
  // Ports toward the memory
  output var ebr_pkg::ebr_port_in_t port_a,
  output var ebr_pkg::ebr_port_in_t port_b
);
  // ========================================================================
  // Enables start high: single clocking takes its output enable from in_ce
  initial begin
    port_a = '0;
    port_a.in_ce = 1'b1;
    port_a.out_ce = 1'b1;
    port_b = port_a;
  end

  // Explicit addresses only; any pointer logic would live here, not in the RAM
  task automatic req(input logic sb, input logic [12:0] ad, input logic [35:0] d,
                     input logic w, input logic r, input logic c);
    ebr_pkg::ebr_port_in_t p;
    p = sb ? port_b : port_a;
    {p.addr, p.wdata, p.we, p.re, p.clr} = {ad, d, w, r, c};
    if (sb) begin
      port_b <= p;
    end else begin
      port_a <= p;
    end
  endtask

  // Released data shows the inverse so a stale word never looks valid
  function automatic ebr_pkg::ebr_port_in_t idle(input ebr_pkg::ebr_port_in_t p);
    p.wdata = ~p.wdata;
    {p.we, p.re, p.clr} = 3'b000;
    return p;
  endfunction

  task automatic rest();
    port_a <= idle(port_a);
    port_b <= idle(port_b);
  endtask

  // Clock enables of one port; never in the same step as req or rest
  task automatic ena(input logic sb, input logic ci, input logic co);
    if (sb) begin
      port_b.in_ce  <= ci;
      port_b.out_ce <= co;
    end else begin
      port_a.in_ce  <= ci;
      port_a.out_ce <= co;
    end
  endtask
endmodule

`default_nettype wire

// [dv/embedded_block_ram_clocking_tb.sv]
// Self-checking bench for the block RAM: AHB-Lite control and fabric traffic.
// Assumes ebr_cfg.svh, ebr_pkg and the fabric model are compiled first.
`include "ebr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module embedded_block_ram_clocking_tb;
  logic                  hclk;
  logic                  hresetn;
  logic                  hwrite;
  logic                  hreadyout;
  logic                  hresp;
  logic [1:0]            htrans;
  logic [31:0]           haddr;
  logic [31:0]           hwdata;
  logic [31:0]           hrdata;
  logic [31:0]           rd;
  logic [35:0]           q_a;
  logic [35:0]           q_b;
  ebr_pkg::ebr_port_in_t port_a;
  ebr_pkg::ebr_port_in_t port_b;
  int                    fail_count;
  int                    samples_checked;
  int                    cyc;
  // Legal memory uses per clock scheme, bit index = use code
  logic [5:0]            ok_mask [4] = '{6'h3f, 6'h0c, 6'h0f, 6'h32};

  ebr_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .port_a(port_a), .port_b(port_b), .q_a(q_a), .q_b(q_b));
  ebr_fabric_model fab (.hclk(hclk), .port_a(port_a), .port_b(port_b));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // ========================================================================
  // Helpers
  task automatic check(input string nm, input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Enabled, both ports x8
  function automatic logic [31:0] cw(input logic [2:0] m, input logic [1:0] c, input logic sp,
                                     input logic mp);
    return {16'h0, mp, sp, 4'h3, 4'h3, c, m, 1'b1};
  endfunction

  // One-edge request, then enough edges for capture, array and output
  task automatic cycle_port();
    @(posedge hclk);
    fab.rest();
    repeat (3) @(posedge hclk);
  endtask

  // Port A writes location 5 while port B reads it in the same cycle
  task automatic coll(input logic [31:0] ctl, input logic [35:0] wd, input logic [35:0] exp);
    ahb(1'b1, `EBR_OFS_CTRL, ctl);
    fab.req(1'b0, 13'h5, wd, 1'b1, 1'b0, 1'b0);
    fab.req(1'b1, 13'h5, 36'h0, 1'b0, 1'b1, 1'b0);
    cycle_port();
    check("q_b", q_b, exp);
  endtask

  // ========================================================================
  // Main sequence
  initial begin
    hresetn = 1'b0;
    htrans = 2'h0;
    haddr = '0;
    hwrite = 1'b0;
    hwdata = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    check("q_a", q_a, 36'h0);
    check("q_b", q_b, 36'h0);
    @(posedge hclk);
    ahb(1'b0, `EBR_OFS_CTRL, 32'h0);
    check("ctrl", {4'h0, rd}, {20'h0, `EBR_CTRL_RST});
    ahb(1'b0, 8'h40, 32'h0);
    check("unmapped", {4'h0, rd}, 36'h0);
    for (int c = 0; c < 4; c++) begin
      for (int m = 0; m < 6; m++) begin
        ahb(1'b1, `EBR_OFS_CTRL, cw(m[2:0], c[1:0], 1'b0, 1'b0));
        ahb(1'b0, `EBR_OFS_STAT, 32'h0);
        check("cfg_err", {35'h0, rd[`EBR_STAT_ERR]}, {35'h0, ~ok_mask[c][m]});
      end
    end
    // Width B raised to x32
    ahb(1'b1, `EBR_OFS_CTRL, cw(3'h2, 2'h0, 1'b0, 1'b0) | 32'h1000);
    ahb(1'b0, `EBR_OFS_STAT, 32'h0);
    check("tdp_x32", {35'h0, rd[`EBR_STAT_ERR]}, 36'h1);
    ahb(1'b1, `EBR_OFS_CTRL, cw(3'h1, 2'h0, 1'b0, 1'b0) | 32'h1000);
    ahb(1'b0, `EBR_OFS_STAT, 32'h0);
    check("sdp_mix", {35'h0, rd[`EBR_STAT_ERR]}, 36'h0);
    ahb(1'b1, `EBR_OFS_CTRL, cw(3'h0, 2'h0, 1'b0, 1'b0));
    fab.req(1'b0, 13'h5, 36'ha5, 1'b1, 1'b0, 1'b0);
    cycle_port();
    fab.req(1'b0, 13'h5, 36'h0, 1'b0, 1'b1, 1'b0);
    cycle_port();
    check("q_a", q_a, 36'ha5);
    fab.req(1'b0, 13'h5, 36'h3c, 1'b1, 1'b1, 1'b0);
    cycle_port();
    check("q_a_old", q_a, 36'ha5);
    ahb(1'b1, `EBR_OFS_CTRL, cw(3'h0, 2'h0, 1'b1, 1'b0));
    fab.req(1'b0, 13'h5, 36'h77, 1'b1, 1'b1, 1'b0);
    cycle_port();
    check("q_a_new", q_a, 36'h77);
    fab.req(1'b0, 13'h0, 36'h0, 1'b0, 1'b0, 1'b1);
    @(posedge hclk);
    fab.rest();
    @(posedge hclk);
    check("q_a_clr", q_a, 36'h0);
    coll(cw(3'h2, 2'h0, 1'b0, 1'b1), 36'h11, 36'h77);
    coll(cw(3'h2, 2'h0, 1'b0, 1'b0), 36'h22, 36'hff);
    coll(cw(3'h1, 2'h3, 1'b0, 1'b1), 36'h33, 36'hff);
    ahb(1'b0, `EBR_OFS_STAT, 32'h0);
    check("coll_cnt", {20'h0, rd[`EBR_STAT_COLL +: 16]}, 36'h3);
    check("hresp", {35'h0, hresp}, 36'h0);
    ahb(1'b1, `EBR_OFS_STAT, 32'h0);
    ahb(1'b0, `EBR_OFS_STAT, 32'h0);
    check("coll_clr", {20'h0, rd[`EBR_STAT_COLL +: 16]}, 36'h0);
    // Output enable low holds q_a although the read went through
    fab.ena(1'b0, 1'b1, 1'b0);
    ahb(1'b1, `EBR_OFS_CTRL, cw(3'h0, 2'h2, 1'b0, 1'b0));
    fab.req(1'b0, 13'h5, 36'h0, 1'b0, 1'b1, 1'b0);
    cycle_port();
    check("q_a_held", q_a, 36'h0);
    fab.ena(1'b0, 1'b1, 1'b1);
    repeat (2) @(posedge hclk);
    check("q_a_out", q_a, 36'h33);
    // Port A switched off: its clear still acts, its write never lands
    fab.ena(1'b0, 1'b0, 1'b0);
    ahb(1'b1, `EBR_OFS_CTRL, cw(3'h2, 2'h1, 1'b0, 1'b0));
    fab.req(1'b0, 13'h5, 36'h99, 1'b1, 1'b0, 1'b1);
    fab.req(1'b1, 13'h5, 36'h0, 1'b0, 1'b1, 1'b0);
    cycle_port();
    check("q_a_off_clr", q_a, 36'h0);
    check("q_b_ind", q_b, 36'h33);
    // Single clock: port A's enable gates port B as well
    ahb(1'b1, `EBR_OFS_CTRL, cw(3'h2, 2'h0, 1'b0, 1'b0));
    fab.req(1'b1, 13'h4, 36'h0, 1'b0, 1'b1, 1'b0);
    cycle_port();
    check("q_b_sc_off", q_b, 36'h33);
    fab.ena(1'b0, 1'b1, 1'b1);
    give_verdict();
  end

  // Whole run is well under a thousand cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc > 5000) begin
      fail_count++;
      give_verdict();
    end
  end
endmodule

`default_nettype wire
